// ==== shared/fpec_pkg.sv ====
// constants and types shared by the flash program/erase controller
//
// What this block does
// - both option bits 0: user program and erases refused, debugger mass erase allowed
// - high-sector bit only: program and page erase in top sector; debugger mass erase
// - array protect bit 1: program and all erases allowed over the whole array
// - reset leaves the controller locked; nothing happens before the key
// - unlock needs 73h then 8ch as two consecutive command writes
// - unlocked: any command write relocks; erase codes run first, then relock
// - invalid value or wrong order on the command register relocks
// - erase codes 95h and 63h count only as third command after the key
// - unlocked, bypass off: each program memory write becomes one byte program
// - byte program only clears bits; erased bytes read ffh
// - processor held idle during a byte program; clock and peripherals run
// - 95h unlocked starts page erase of the selected 512 byte page
// - processor idles during page erase; controller relocks when it ends
// - 63h unlocked starts mass erase of the array, processor idling
// - mass erase completion returns the controller to locked
// - command write and status read share register address ff8h
// - status codes: 0 locked, 1 key one, 2 unlocked, 08/10/20 busy
// - bypass routes array controls to pins; erases still run
// - erased page is address bits 15 to 9 equal to page select
package fpec_pkg;
  localparam logic [11:0] FPEC_ADDR_CMD = 12'hff8;
  localparam logic [11:0] FPEC_ADDR_PAGE = 12'hff9;
  localparam logic [11:0] FPEC_ADDR_KHZ_HI = 12'hffa;
  localparam logic [11:0] FPEC_ADDR_KHZ_LO = 12'hffb;
  localparam logic [7:0] FPEC_KEY_FIRST = 8'h73;
  localparam logic [7:0] FPEC_KEY_SECOND = 8'h8c;
  localparam logic [7:0] FPEC_CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] FPEC_CMD_MASS_ERASE = 8'h63;
  localparam logic [5:0] FPEC_ST_LOCKED = 6'h00;
  localparam logic [5:0] FPEC_ST_KEY1 = 6'h01;
  localparam logic [5:0] FPEC_ST_UNLOCKED = 6'h02;
  localparam logic [5:0] FPEC_ST_PROG = 6'h08;
  localparam logic [5:0] FPEC_ST_PAGE = 6'h10;
  localparam logic [5:0] FPEC_ST_MASS = 6'h20;
  localparam logic [7:0] FPEC_RESET_BYTE = 8'h00;
  localparam logic [7:0] FPEC_ERASED_BYTE = 8'hff;
  localparam int FPEC_PAGE_LSB = 9;
  // operation times in microseconds, scaled by the kilohertz value
  localparam int FPEC_PROG_TIME_US = 40;
  localparam int FPEC_PAGE_TIME_US = 10000;
  localparam int FPEC_MASS_TIME_US = 200000;
  localparam int FPEC_US_PER_MS = 1000;
  typedef enum logic [1:0] {
    FPEC_OP_PROG,
    FPEC_OP_PAGE,
    FPEC_OP_MASS
  } fpec_op_t;
  typedef enum {
    FPEC_LOCKED,
    FPEC_KEY1,
    FPEC_UNLOCKED,
    FPEC_PROGRAM,
    FPEC_PAGE_ERASE,
    FPEC_MASS_ERASE
  } fpec_state_t;
endpackage

// ==== src/fpec_guard.sv ====
// option-bit protection check for program and erase requests
`timescale 1ns/100ps
module fpec_guard
  import fpec_pkg::*;
#(
  parameter int FLASH_BYTES = 65536,
  parameter int HIGH_BYTES = 4096
) (
  // option bits, captured
  input wire logic high_sector_protect_opt,
  input wire logic array_protect_opt,
  // request
  input wire logic [15:0] prog_addr,
  input wire logic [6:0] erase_page_select,
  input wire logic from_debugger,
  // verdicts
  output logic prog_ok,
  output logic page_ok,
  output logic mass_ok
);
  localparam logic [16:0] HIGH_BASE = 17'(FLASH_BYTES - HIGH_BYTES);
  logic [16:0] page_base;
  assign page_base = {1'b0, erase_page_select, 9'h000};
  always_comb begin
    if (array_protect_opt) begin
      prog_ok = 1'b1;
      page_ok = 1'b1;
      mass_ok = 1'b1;
    end else if (high_sector_protect_opt) begin
      prog_ok = ({1'b0, prog_addr} >= HIGH_BASE);
      page_ok = (page_base >= HIGH_BASE);
      mass_ok = from_debugger;
    end else begin
      prog_ok = 1'b0;
      page_ok = 1'b0;
      mass_ok = from_debugger;
    end
  end
endmodule

// ==== src/fpec_timer.sv ====
// program/erase duration counter scaled by the kilohertz value
`timescale 1ns/100ps
module fpec_timer
  import fpec_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input fpec_op_t op,
  input wire logic [15:0] clock_khz_value,
  // completion
  output logic done
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;
  logic done_ff;
  logic nxt_done;
  logic [47:0] scaled;
  logic [31:0] load;
  always_comb begin
    scaled = 48'h0;
    case (op)
      FPEC_OP_PROG: scaled = 48'(clock_khz_value) * 48'(FPEC_PROG_TIME_US);
      FPEC_OP_PAGE: scaled = 48'(clock_khz_value) * 48'(FPEC_PAGE_TIME_US);
      default: scaled = 48'(clock_khz_value) * 48'(FPEC_MASS_TIME_US);
    endcase
    // khz times us over 1000 gives cycles; an unloaded value still ends
    load = 32'(scaled / 48'(FPEC_US_PER_MS));
    if (load == 32'h0) begin
      load = 32'h1;
    end
  end
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt = load;
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      if (cnt_ff <= 32'h1) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 32'h1;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= 32'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end
  assign done = done_ff;
endmodule

// ==== src/fpec_ctrl.sv ====
// flash lock/unlock sequencer and program/erase controller
`timescale 1ns/100ps
module fpec_ctrl
  import fpec_pkg::*;
#(
  parameter int FLASH_BYTES = 65536,
  parameter int HIGH_BYTES = 4096
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register file port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_from_dbg,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // program memory writes from processor or debugger
  input wire logic pm_wr,
  input wire logic [15:0] pm_addr,
  input wire logic [7:0] pm_wdata,
  input wire logic [7:0] pm_old_data,
  // option bits, sampled after reset
  input wire logic high_sector_protect_opt,
  input wire logic array_protect_opt,
  // bypass pins
  input wire logic bypass_en,
  input wire logic byp_prog,
  input wire logic [15:0] byp_addr,
  input wire logic [7:0] byp_data,
  // flash array controls
  output logic arr_prog,
  output logic arr_page_erase,
  output logic arr_mass_erase,
  output logic [15:0] arr_addr,
  output logic [7:0] arr_data,
  // processor stall
  output logic cpu_hold
);
  // sizes the guard cannot serve stop the build, not the run
  if (HIGH_BYTES < 1024 || HIGH_BYTES > 4096 || FLASH_BYTES > 65536
      || FLASH_BYTES < 2 * HIGH_BYTES || HIGH_BYTES % 512 != 0
      || FLASH_BYTES % 512 != 0) begin : g_bad_size
    $error("fpec_ctrl: unsupported flash or high sector size");
  end

  ////////////////////////////////////////////////////////////////////////
  // register file: page select and kilohertz value

  logic [6:0] page_ff;
  logic [6:0] nxt_page;
  logic [15:0] khz_ff;
  logic [15:0] nxt_khz;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [5:0] status;
  logic wr_cmd;

  // page and khz stay writable during an op; the running op keeps its own copy
  assign wr_cmd = reg_wr && (reg_addr == FPEC_ADDR_CMD);

  always_comb begin
    nxt_page = page_ff;
    nxt_khz = khz_ff;
    nxt_rdata = rdata_ff;
    // khz comes a byte at a time; an op started between the two sees a mix
    if (reg_wr) begin
      if (reg_addr == FPEC_ADDR_PAGE) begin
        nxt_page = reg_wdata[6:0];
      end else if (reg_addr == FPEC_ADDR_KHZ_HI) begin
        nxt_khz = {reg_wdata, khz_ff[7:0]};
      end else if (reg_addr == FPEC_ADDR_KHZ_LO) begin
        nxt_khz = {khz_ff[15:8], reg_wdata};
      end
    end
    if (reg_rd) begin
      if (reg_addr == FPEC_ADDR_CMD) begin
        nxt_rdata = {2'b00, status};
      end else if (reg_addr == FPEC_ADDR_PAGE) begin
        nxt_rdata = {1'b0, page_ff};
      end else if (reg_addr == FPEC_ADDR_KHZ_HI) begin
        nxt_rdata = khz_ff[15:8];
      end else if (reg_addr == FPEC_ADDR_KHZ_LO) begin
        nxt_rdata = khz_ff[7:0];
      end else begin
        nxt_rdata = FPEC_RESET_BYTE;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_ff <= 7'h00;
      khz_ff <= 16'h0000;
      rdata_ff <= FPEC_RESET_BYTE;
    end else begin
      page_ff <= nxt_page;
      khz_ff <= nxt_khz;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // option bit capture

  // straps are caught by a clocked load after release, never by the reset
  logic opt_valid_ff;
  logic nxt_opt_valid;
  logic hsp_ff;
  logic nxt_hsp;
  logic ap_ff;
  logic nxt_ap;

  always_comb begin
    nxt_opt_valid = 1'b1;
    nxt_hsp = hsp_ff;
    nxt_ap = ap_ff;
    if (!opt_valid_ff) begin
      nxt_hsp = high_sector_protect_opt;
      nxt_ap = array_protect_opt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opt_valid_ff <= 1'b0;
      hsp_ff <= 1'b0;
      ap_ff <= 1'b0;
    end else begin
      opt_valid_ff <= nxt_opt_valid;
      hsp_ff <= nxt_hsp;
      ap_ff <= nxt_ap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // protection and timing helpers

  logic prog_ok;
  logic page_ok;
  logic mass_ok;
  logic tmr_start;
  fpec_op_t tmr_op;
  logic tmr_done;

  // verdicts follow the request combinationally and count at the taking edge
  fpec_guard #(
    .FLASH_BYTES(FLASH_BYTES),
    .HIGH_BYTES(HIGH_BYTES)
  ) u_guard (
    .high_sector_protect_opt(hsp_ff),
    .array_protect_opt(ap_ff),
    .prog_addr(pm_addr),
    .erase_page_select(page_ff),
    .from_debugger(reg_from_dbg),
    .prog_ok(prog_ok),
    .page_ok(page_ok),
    .mass_ok(mass_ok)
  );

  // one timer serves all ops, since only one can run at a time
  fpec_timer u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(tmr_start),
    .op(tmr_op),
    .clock_khz_value(khz_ff),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // lock sequencer and operation control

  fpec_state_t state_ff;
  fpec_state_t nxt_state;
  logic [15:0] op_addr_ff;
  logic [15:0] nxt_op_addr;
  logic [7:0] op_data_ff;
  logic [7:0] nxt_op_data;

  always_comb begin
    nxt_state = state_ff;
    nxt_op_addr = op_addr_ff;
    nxt_op_data = op_data_ff;
    tmr_start = 1'b0;
    tmr_op = FPEC_OP_PROG;
    case (state_ff)
      FPEC_LOCKED: begin
        // program writes fall through untouched here
        if (wr_cmd && reg_wdata == FPEC_KEY_FIRST) begin
          nxt_state = FPEC_KEY1;
        end
      end
      FPEC_KEY1: begin
        if (wr_cmd) begin
          if (reg_wdata == FPEC_KEY_SECOND) begin
            nxt_state = FPEC_UNLOCKED;
          end else begin
            nxt_state = FPEC_LOCKED;
          end
        end
      end
      FPEC_UNLOCKED: begin
        if (wr_cmd) begin
          // the key pair or a finished byte program leads here; byte programs are no command writes, so this write is the third one
          if (reg_wdata == FPEC_CMD_PAGE_ERASE && page_ok) begin
            nxt_state = FPEC_PAGE_ERASE;
            nxt_op_addr = 16'(page_ff) << FPEC_PAGE_LSB;
            nxt_op_data = FPEC_ERASED_BYTE;
            tmr_start = 1'b1;
            tmr_op = FPEC_OP_PAGE;
          end else if (reg_wdata == FPEC_CMD_MASS_ERASE && mass_ok) begin
            nxt_state = FPEC_MASS_ERASE;
            nxt_op_addr = 16'h0000;
            nxt_op_data = FPEC_ERASED_BYTE;
            tmr_start = 1'b1;
            tmr_op = FPEC_OP_MASS;
          end else begin
            // a refused erase code also lands here and relocks, array untouched
            nxt_state = FPEC_LOCKED;
          end
        end else if (pm_wr && prog_ok && !bypass_en) begin
          nxt_state = FPEC_PROGRAM;
          nxt_op_addr = pm_addr;
          // merging with the old byte means a 0 bit can never rise again
          nxt_op_data = pm_wdata & pm_old_data;
          tmr_start = 1'b1;
          tmr_op = FPEC_OP_PROG;
        end
      end
      FPEC_PROGRAM: begin
        // command writes are dropped until the byte is done
        if (tmr_done) begin
          nxt_state = FPEC_UNLOCKED;
        end
      end
      FPEC_PAGE_ERASE: begin
        if (tmr_done) begin
          // the erase code was the last command, so the lock closes when it ends
          nxt_state = FPEC_LOCKED;
        end
      end
      FPEC_MASS_ERASE: begin
        if (tmr_done) begin
          nxt_state = FPEC_LOCKED;
        end
      end
      default: begin
        nxt_state = FPEC_LOCKED;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= FPEC_LOCKED;
      op_addr_ff <= 16'h0000;
      op_data_ff <= FPEC_ERASED_BYTE;
    end else begin
      state_ff <= nxt_state;
      op_addr_ff <= nxt_op_addr;
      op_data_ff <= nxt_op_data;
    end
  end

  always_comb begin
    // busy codes leave the low three bits at 0; no sub-step is shown
    case (state_ff)
      FPEC_KEY1: status = FPEC_ST_KEY1;
      FPEC_UNLOCKED: status = FPEC_ST_UNLOCKED;
      FPEC_PROGRAM: status = FPEC_ST_PROG;
      FPEC_PAGE_ERASE: status = FPEC_ST_PAGE;
      FPEC_MASS_ERASE: status = FPEC_ST_MASS;
      default: status = FPEC_ST_LOCKED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // array drive, bypass mux and processor hold

  logic prog_ff;
  logic nxt_prog;
  logic page_er_ff;
  logic nxt_page_er;
  logic mass_er_ff;
  logic nxt_mass_er;
  logic [15:0] aaddr_ff;
  logic [15:0] nxt_aaddr;
  logic [7:0] adata_ff;
  logic [7:0] nxt_adata;
  logic hold_ff;
  logic nxt_hold;

  always_comb begin
    nxt_prog = (nxt_state == FPEC_PROGRAM);
    nxt_page_er = (nxt_state == FPEC_PAGE_ERASE);
    nxt_mass_er = (nxt_state == FPEC_MASS_ERASE);
    nxt_aaddr = nxt_op_addr;
    nxt_adata = nxt_op_data;
    // erases keep ownership of the array even with bypass on
    if (bypass_en && !nxt_page_er && !nxt_mass_er) begin
      nxt_prog = byp_prog;
      nxt_aaddr = byp_addr;
      nxt_adata = byp_data;
    end
    // one cycle after the request the processor is already stalled
    nxt_hold = (nxt_state == FPEC_PROGRAM)
      || (nxt_state == FPEC_PAGE_ERASE)
      || (nxt_state == FPEC_MASS_ERASE);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_ff <= 1'b0;
      page_er_ff <= 1'b0;
      mass_er_ff <= 1'b0;
      aaddr_ff <= 16'h0000;
      adata_ff <= FPEC_ERASED_BYTE;
      hold_ff <= 1'b0;
    end else begin
      prog_ff <= nxt_prog;
      page_er_ff <= nxt_page_er;
      mass_er_ff <= nxt_mass_er;
      aaddr_ff <= nxt_aaddr;
      adata_ff <= nxt_adata;
      hold_ff <= nxt_hold;
    end
  end

  // every array and hold output is a flop, so no decode glitch reaches the array
  assign arr_prog = prog_ff;
  assign arr_page_erase = page_er_ff;
  assign arr_mass_erase = mass_er_ff;
  assign arr_addr = aaddr_ff;
  assign arr_data = adata_ff;
  assign cpu_hold = hold_ff;
endmodule

// ==== test/fpec_ctrl_monitor.sv ====
// assertion checker for the flash program/erase controller
`timescale 1ns/100ps
module fpec_ctrl_monitor
  import fpec_pkg::*;
#(
  parameter int FLASH_BYTES = 65536,
  parameter int HIGH_BYTES = 4096
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_from_dbg,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // program writes, options, bypass
  input wire logic pm_wr,
  input wire logic [15:0] pm_addr,
  input wire logic [7:0] pm_wdata,
  input wire logic [7:0] pm_old_data,
  input wire logic high_sector_protect_opt,
  input wire logic array_protect_opt,
  input wire logic bypass_en,
  // array side
  input wire logic arr_prog,
  input wire logic arr_page_erase,
  input wire logic arr_mass_erase,
  input wire logic [15:0] arr_addr,
  input wire logic [7:0] arr_data,
  input wire logic cpu_hold
);
  default clocking cb_mon @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic cmd_wr;
  assign cmd_wr = reg_wr && reg_addr == FPEC_ADDR_CMD;
  ////////////////////////////////////////////////////////////////////////////////
  AST_ERASE_HOLD: assert property ((arr_page_erase || arr_mass_erase) |-> cpu_hold)
    else $error("erase without processor hold");
  AST_PROG_HOLD: assert property (arr_prog && !bypass_en && !$past(bypass_en) |-> cpu_hold)
    else $error("byte program without processor hold");
  AST_PAGE_START: assert property ($rose(arr_page_erase) |->
    $past(cmd_wr && reg_wdata == FPEC_CMD_PAGE_ERASE))
    else $error("page erase without its command");
  AST_MASS_START: assert property ($rose(arr_mass_erase) |->
    $past(cmd_wr && reg_wdata == FPEC_CMD_MASS_ERASE))
    else $error("mass erase without its command");
  AST_PROG_DATA: assert property ($rose(arr_prog) && !$past(bypass_en) |-> $past(pm_wr) &&
    arr_addr == $past(pm_addr) && arr_data == $past(pm_wdata & pm_old_data))
    else $error("byte program address or data wrong");
  AST_ERASE_FORM: assert property (arr_page_erase |->
    arr_addr[8:0] == 9'h000 && arr_data == FPEC_ERASED_BYTE)
    else $error("page erase address or data wrong");
  AST_MASS_FORM: assert property (arr_mass_erase |->
    arr_addr == 16'h0000 && arr_data == FPEC_ERASED_BYTE)
    else $error("mass erase address or data wrong");
  AST_NO_PROT: assert property (!high_sector_protect_opt && !array_protect_opt && !bypass_en &&
    !$past(bypass_en) |-> !arr_prog && !arr_page_erase)
    else $error("program or page erase while fully protected");
  AST_HIGH_ONLY: assert property (high_sector_protect_opt && !array_protect_opt &&
    (arr_page_erase || ($rose(arr_prog) && !$past(bypass_en))) |->
    arr_addr >= 16'(FLASH_BYTES - HIGH_BYTES))
    else $error("program or erase below the high sector");
  AST_USER_MASS: assert property (!array_protect_opt && $rose(arr_mass_erase) |->
    $past(reg_from_dbg))
    else $error("user mass erase under protection");
  AST_STATUS_BUSY: assert property (reg_rd && reg_addr == FPEC_ADDR_CMD && arr_page_erase |=>
    reg_rdata == 8'h10)
    else $error("status wrong during page erase");
  AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  ////////////////////////////////////////////////////////////////////////////////
  cover property ($rose(arr_page_erase));
  cover property ($rose(arr_mass_erase) && $past(reg_from_dbg));
  cover property ($rose(arr_prog) && !bypass_en);
endmodule

bind fpec_ctrl fpec_ctrl_monitor #(
  .FLASH_BYTES(FLASH_BYTES),
  .HIGH_BYTES(HIGH_BYTES)
) mon_u (
  .sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_from_dbg, .reg_wdata, .reg_rdata,
  .pm_wr, .pm_addr, .pm_wdata, .pm_old_data, .high_sector_protect_opt, .array_protect_opt,
  .bypass_en, .arr_prog, .arr_page_erase, .arr_mass_erase, .arr_addr, .arr_data, .cpu_hold
);

// ==== test/fpec_flash_model.sv ====
// flash array model fed by the controller's array controls
`timescale 1ns/100ps
module fpec_flash_model (
  // clock
  input wire logic sys_clk,
  // array controls
  input wire logic arr_prog,
  input wire logic arr_page_erase,
  input wire logic arr_mass_erase,
  input wire logic [15:0] arr_addr,
  input wire logic [7:0] arr_data,
  // current byte at the program target
  input wire logic [15:0] look_addr,
  output logic [7:0] look_data
);
  logic [7:0] mem [65536];
  // stores what it is given, so a missing bit mask shows in the bench
  initial begin
    foreach (mem[i])
      mem[i] = 8'hff;
  end
  assign look_data = mem[look_addr];
  always @(posedge sys_clk) begin
    if (arr_prog)
      mem[arr_addr] <= arr_data;
    if (arr_page_erase)
      for (int i = 0; i < 512; i++)
        mem[{arr_addr[15:9], 9'(i)}] <= 8'hff;
    if (arr_mass_erase)
      foreach (mem[i])
        mem[i] <= 8'hff;
  end
endmodule

// ==== test/fpec_ctrl_test.sv ====
// self-checking bench for the flash program/erase controller
`timescale 1ns/100ps
module fpec_ctrl_test
  import fpec_pkg::*;
;
  localparam logic [11:0] CMD = FPEC_ADDR_CMD;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_from_dbg = 1'b0;
  logic pm_wr = 1'b0, high_sector_protect_opt = 1'b0, array_protect_opt = 1'b1;
  logic bypass_en = 1'b0, byp_prog = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, pm_wdata = 8'h00, byp_data = 8'h00;
  logic [15:0] pm_addr = 16'h0000, byp_addr = 16'h0000, arr_addr;
  logic [7:0] reg_rdata, pm_old_data, arr_data, v;
  logic arr_prog, arr_page_erase, arr_mass_erase, cpu_hold;
  int n_mismatch = 0, num_checks = 0;

  fpec_ctrl dut_u (
    .sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_from_dbg, .reg_wdata, .reg_rdata,
    .pm_wr, .pm_addr, .pm_wdata, .pm_old_data, .high_sector_protect_opt, .array_protect_opt,
    .bypass_en, .byp_prog, .byp_addr, .byp_data, .arr_prog, .arr_page_erase,
    .arr_mass_erase, .arr_addr, .arr_data, .cpu_hold
  );
  fpec_flash_model mdl_u (
    .sys_clk, .arr_prog, .arr_page_erase, .arr_mass_erase, .arr_addr, .arr_data,
    .look_addr(pm_addr), .look_data(pm_old_data)
  );
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic hs, input logic ap);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    high_sector_protect_opt <= hs;
    array_protect_opt <= ap;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic dbg = 1'b0);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_from_dbg <= dbg;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_from_dbg <= 1'b0;
  endtask
  task automatic rdv(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    rdv(a, v);
    chk(v, exp);
  endtask
  task automatic pw(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    pm_wr <= 1'b1;
    pm_addr <= a;
    pm_wdata <= d;
    @(posedge sys_clk);
    pm_wr <= 1'b0;
  endtask
  task automatic unlock();
    wr(CMD, FPEC_KEY_FIRST);
    wr(CMD, FPEC_KEY_SECOND);
  endtask
  // refused operations are watched a few cycles only
  task automatic wait_op(input bit exp);
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge sys_clk);
      #1;
      if (cpu_hold === 1'b1)
        seen = 1'b1;
      else if (seen || (!exp && i > 4))
        break;
    end
    num_checks++;
    if (seen !== exp || cpu_hold !== 1'b0) begin
      n_mismatch++;
      $display("[FAIL] %0t hold seen %b expected %b", $time, seen, exp);
      if (cpu_hold !== 1'b0 || (exp && !seen))
        stop_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_locked();
    rd(CMD, 8'h00);
    rd(12'hffc, 8'h00);
    pw(16'h0200, 8'h00);
    wait_op(1'b0);
    chk(mdl_u.mem[16'h0200], 8'hff);
  endtask
  task automatic t_prog();
    wr(CMD, FPEC_KEY_FIRST);
    rd(CMD, 8'h01);
    wr(CMD, FPEC_KEY_SECOND);
    rd(CMD, 8'h02);
    pw(16'h1234, 8'h5a);
    wait_op(1'b1);
    chk(mdl_u.mem[16'h1234], 8'h5a);
    pw(16'h1234, 8'hf0);
    wait_op(1'b1);
    chk(mdl_u.mem[16'h1234], 8'h50);
    rd(CMD, 8'h02);
    wr(CMD, 8'h00);
    rd(CMD, 8'h00);
    pw(16'h1235, 8'h00);
    wait_op(1'b0);
  endtask
  task automatic t_bad();
    wr(CMD, FPEC_KEY_FIRST);
    wr(CMD, 8'h55);
    rd(CMD, 8'h00);
    wr(CMD, FPEC_KEY_FIRST);
    wr(CMD, FPEC_CMD_PAGE_ERASE);
    wait_op(1'b0);
    rd(CMD, 8'h00);
    wr(CMD, FPEC_KEY_SECOND);
    rd(CMD, 8'h00);
    wr(CMD, FPEC_CMD_MASS_ERASE);
    wait_op(1'b0);
  endtask
  task automatic t_page();
    wr(FPEC_ADDR_KHZ_HI, 8'h00);
    wr(FPEC_ADDR_KHZ_LO, 8'h01);
    wr(FPEC_ADDR_PAGE, 8'h09);
    unlock();
    pw(16'h1400, 8'h3c);
    wait_op(1'b1);
    wr(CMD, FPEC_CMD_PAGE_ERASE);
    rd(CMD, 8'h10);
    wr(CMD, FPEC_KEY_FIRST);
    wait_op(1'b1);
    rd(CMD, 8'h00);
    chk(mdl_u.mem[16'h1234], 8'hff);
    chk(mdl_u.mem[16'h1400], 8'h3c);
  endtask
  task automatic t_mass();
    unlock();
    wr(CMD, FPEC_CMD_MASS_ERASE, 1'b1);
    rd(CMD, 8'h20);
    for (int i = 0; i < 400 && v !== 8'h00; i++)
      rdv(CMD, v);
    chk(v, 8'h00);
    if (v !== 8'h00)
      stop_test();
    chk(mdl_u.mem[16'h1400], 8'hff);
  endtask
  task automatic t_prot();
    rst(1'b0, 1'b0);
    unlock();
    pw(16'h0300, 8'h00);
    wait_op(1'b0);
    wr(CMD, FPEC_CMD_PAGE_ERASE);
    wait_op(1'b0);
    unlock();
    wr(CMD, FPEC_CMD_MASS_ERASE, 1'b1);
    wait_op(1'b1);
    rst(1'b1, 1'b0);
    wr(FPEC_ADDR_PAGE, 8'h78);
    unlock();
    pw(16'hf000, 8'ha5);
    wait_op(1'b1);
    pw(16'hefff, 8'h00);
    wait_op(1'b0);
    chk(mdl_u.mem[16'hefff], 8'hff);
    wr(CMD, FPEC_CMD_MASS_ERASE);
    wait_op(1'b0);
    unlock();
    wr(CMD, FPEC_CMD_PAGE_ERASE);
    wait_op(1'b1);
    chk(mdl_u.mem[16'hf000], 8'hff);
  endtask
  task automatic t_bypass();
    rst(1'b1, 1'b1);
    @(posedge sys_clk);
    bypass_en <= 1'b1;
    byp_prog <= 1'b1;
    byp_addr <= 16'h0042;
    byp_data <= 8'h11;
    repeat (2) @(posedge sys_clk);
    byp_prog <= 1'b0;
    @(posedge sys_clk);
    chk(mdl_u.mem[16'h0042], 8'h11);
    wr(FPEC_ADDR_PAGE, 8'h00);
    unlock();
    wr(CMD, FPEC_CMD_PAGE_ERASE);
    wait_op(1'b1);
    chk(mdl_u.mem[16'h0042], 8'hff);
    @(posedge sys_clk);
    bypass_en <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst(1'b0, 1'b1);
    t_locked();
    t_prog();
    t_bad();
    t_page();
    t_mass();
    t_prot();
    t_bypass();
    stop_test();
  end
endmodule
